//--- rtl/dgram_dev.sv
// Device end: 40-bit datagram slave with a 128-entry register file.
// Assumes the link pins are asynchronous to mclk and the serial clock
// runs at most at an eighth of mclk.
//
// Behaviour
// - Transaction is one 40-bit frame.
// - Host holds select low whole frame.
// - Address byte then 32-bit data word.
// - Always 32 data bits transferred.
// - Top address bit zero means read.
// - Top address bit one writes data, except to read-only registers.
// - Registers write-only, read/write or read-only.
// - Frames shift most significant bit first.
// - Status byte returned in top eight bits.
// - Return previous read data or write data.
// - Longer frames keep last 40 bits.
`default_nettype none
module dgram_dev
    import dgram_pkg::*;
(
    input  wire logic        mclk,        // System clock.
    input  wire logic        sys_rst,     // Asynchronous reset, active high.
    input  wire logic        clk_en,      // Freezes all state when low.
    dgram_if.dev             link,        // Serial link.
    input  wire logic [7:0]  status_in,   // Status flags sent each frame.
    input  wire logic [31:0] ro_value,    // Value for read-only registers.
    output logic             wr_strobe,   // Pulse when a register is written.
    output logic [6:0]       wr_index,    // Index of the last write.
    output logic [31:0]      wr_data      // Data of the last write.
);

    // Pin synchronisers. The serial clock has a third stage so that its
    // edges are found from a stage of the same age as the data stage.
    logic [2:0]  sck_sync_ff;
    logic [1:0]  sel_sync_ff;
    logic [1:0]  mosi_sync_ff;
    logic        sel_prev_ff;

    // Receive side: frame shift register and its saturating bit counter.
    logic [39:0] shift_ff;
    logic [39:0] nxt_shift;
    logic [5:0]  bit_cnt_ff;
    logic [5:0]  nxt_bit_cnt;

    // Transmit side: reply shift register and the line driver flop.
    logic [39:0] reply_ff;
    logic [39:0] nxt_reply;
    logic        miso_ff;
    logic        nxt_miso;

    // Register file and the write report towards the core.
    logic        wr_strobe_ff;
    logic        nxt_wr_strobe;
    logic [6:0]  wr_index_ff;
    logic [6:0]  nxt_wr_index;
    logic [31:0] wr_data_ff;
    logic [31:0] nxt_wr_data;
    logic [31:0] regs_ff [REG_COUNT];

    // Pin decode. Clock edges only count while the frame is selected, so a
    // host that moves its clock between frames cannot corrupt the counter.
    wire         sck_rise  = sck_sync_ff[1] & ~sck_sync_ff[2];
    wire         sck_fall  = ~sck_sync_ff[1] & sck_sync_ff[2];
    wire         selected  = ~sel_sync_ff[1];
    wire         sel_start = selected & ~sel_prev_ff;
    wire         sel_end   = ~selected & sel_prev_ff;
    wire         take_bit  = selected & sck_rise;
    wire         give_bit  = selected & sck_fall;
    wire [39:0]  shifted   = {shift_ff[38:0], mosi_sync_ff[1]};
    wire         cnt_full  = bit_cnt_ff == FRAME_BITS[5:0];

    // Command decode. It is only acted on in the cycle the frame ends.
    wire         is_write  = shift_ff[ADDR_MSB];
    wire [6:0]   index     = shift_ff[ADDR_LSB+INDEX_BITS-1:ADDR_LSB];
    wire [31:0]  word      = shift_ff[DATA_BITS-1:0];
    wire [1:0]   acc       = access_of(index);
    wire         can_write = acc != ACC_RO;
    wire [31:0]  rd_value  = (acc == ACC_RO) ? ro_value :
                             (acc == ACC_RW) ? regs_ff[index] : REG_RST;
    wire [31:0]  nxt_data  = is_write ? word : rd_value;
    // Shorter frames are dropped whole; longer ones keep their last 40 bits.
    wire         frame_ok  = sel_end & cnt_full;
    wire         do_write  = frame_ok & is_write & can_write;

    // Receive path. The counter saturates so that an over-long frame still
    // ends with a full count while the register keeps only the newest bits.
    always_comb begin
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift   = shift_ff;
        if (sel_start) begin
            nxt_bit_cnt = BIT_CNT_RST;
        end else if (take_bit) begin
            nxt_shift = shifted;
            if (!cnt_full) begin
                nxt_bit_cnt = bit_cnt_ff + 6'h01;
            end
        end
    end

    // Reply path. The status byte goes in at frame start; the data word was
    // prepared when the previous frame ended. A bit is put on the line after
    // each falling clock edge, so the host finds it settled at the rise.
    // Bits beyond 40 come from the receive register, which lets a longer
    // frame pass the host's data on to a chained device.
    always_comb begin
        nxt_reply = reply_ff;
        nxt_miso  = miso_ff;
        if (sel_start) begin
            nxt_reply[ADDR_MSB:ADDR_LSB] = status_in;
            nxt_miso                     = status_in[7];
        end else if (give_bit) begin
            nxt_miso  = reply_ff[ADDR_MSB];
            nxt_reply = {reply_ff[38:0], shift_ff[39]};
        end
        if (frame_ok) begin
            nxt_reply[DATA_BITS-1:0] = nxt_data;
        end
    end

    // Write report. Writes aimed at read-only indexes are dropped silently;
    // the reply still mirrors their data, as for any other write.
    always_comb begin
        nxt_wr_strobe = do_write;
        nxt_wr_index  = wr_index_ff;
        nxt_wr_data   = wr_data_ff;
        if (do_write) begin
            nxt_wr_index = index;
            nxt_wr_data  = word;
        end
    end

    // The select synchroniser resets to the deselected level, so that no
    // false frame start follows the release of reset.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sck_sync_ff  <= 3'h7;
            sel_sync_ff  <= 2'h3;
            mosi_sync_ff <= 2'h0;
            sel_prev_ff  <= 1'b0;
        end else if (clk_en) begin
            sck_sync_ff  <= {sck_sync_ff[1:0], link.sclk};
            sel_sync_ff  <= {sel_sync_ff[0], link.select_low_line};
            mosi_sync_ff <= {mosi_sync_ff[0], link.mosi};
            sel_prev_ff  <= selected;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_ff   <= {FRAME_BITS{1'b0}};
            bit_cnt_ff <= BIT_CNT_RST;
        end else if (clk_en) begin
            shift_ff   <= nxt_shift;
            bit_cnt_ff <= nxt_bit_cnt;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reply_ff <= {FRAME_BITS{1'b0}};
            miso_ff  <= 1'b0;
        end else if (clk_en) begin
            reply_ff <= nxt_reply;
            miso_ff  <= nxt_miso;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_strobe_ff <= 1'b0;
            wr_index_ff  <= 7'h00;
            wr_data_ff   <= REG_RST;
        end else if (clk_en) begin
            wr_strobe_ff <= nxt_wr_strobe;
            wr_index_ff  <= nxt_wr_index;
            wr_data_ff   <= nxt_wr_data;
        end
    end

    // One process per entry keeps the write decode local to each word.
    // The whole file is kept in flops; a memory macro would lose the reset.
    for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                regs_ff[g] <= REG_RST;
            end else if (clk_en && do_write && index == 7'(g)) begin
                regs_ff[g] <= word;
            end
        end
    end

    assign link.miso = miso_ff;
    assign wr_strobe = wr_strobe_ff;
    assign wr_index  = wr_index_ff;
    assign wr_data   = wr_data_ff;
endmodule : dgram_dev
`default_nettype wire

//--- rtl/dgram_pkg.sv
// Shared constants for the 40-bit serial datagram link.
// Assumes both ends run on one 50 MHz system clock.
`default_nettype none
package dgram_pkg;
    localparam int unsigned FRAME_BITS   = 40;
    localparam int unsigned ADDR_MSB     = 39;
    localparam int unsigned ADDR_LSB     = 32;
    localparam int unsigned DATA_BITS    = 32;
    localparam int unsigned WRITE_BIT    = 7;
    localparam int unsigned INDEX_BITS   = 7;
    localparam int unsigned REG_COUNT    = 128;
    localparam int unsigned CLK_DIV      = 8;
    localparam logic [31:0] REG_RST      = 32'h0000_0000;
    localparam logic [7:0]  STATUS_RST   = 8'h00;
    localparam logic [1:0]  ACC_WO       = 2'h0;
    localparam logic [1:0]  ACC_RW       = 2'h1;
    localparam logic [1:0]  ACC_RO       = 2'h2;
    localparam logic [5:0]  BIT_CNT_RST  = 6'h00;
    localparam logic [3:0]  DIV_CNT_RST  = 4'h0;

    // Access type per register index: low quarter read/write,
    // top quarter read-only, the rest write-only.
    function automatic logic [1:0] access_of(input logic [6:0] idx);
        if (idx[6:5] == 2'h3) begin
            return ACC_RO;
        end else if (idx[6:5] == 2'h0) begin
            return ACC_RW;
        end
        return ACC_WO;
    endfunction : access_of
endpackage : dgram_pkg
`default_nettype wire

//--- rtl/dgram_if.sv
// Serial link wires between the host and the device.
// Assumes the bench connects both modports to one instance.
`default_nettype none
interface dgram_if;
    logic sclk;             // Serial clock, host driven, idles high.
    logic select_low_line;  // Frame select, active low.
    logic mosi;             // Host to device data.
    logic miso;             // Device to host data.
    modport host (output sclk, output select_low_line, output mosi, input miso);
    modport dev  (input sclk, input select_low_line, input mosi, output miso);
endinterface : dgram_if
`default_nettype wire

//--- rtl/dgram_host.sv
// Host end: sends one 40-bit datagram per request and returns the reply.
// Assumes the device samples on rising and drives after falling sclk.
`default_nettype none
module dgram_host
    import dgram_pkg::*;
(
    input  wire logic        mclk,      // System clock.
    input  wire logic        sys_rst,   // Asynchronous reset, active high.
    input  wire logic        clk_en,    // Freezes all state when low.
    dgram_if.host            link,      // Serial link.
    input  wire logic        req,       // Start a frame when idle.
    input  wire logic        req_write, // One for write, zero for read.
    input  wire logic [6:0]  req_index, // Register index.
    input  wire logic [31:0] req_data,  // Write data, dummy for reads.
    output logic             busy,      // High while a frame runs.
    output logic             done,      // Pulse when a reply is ready.
    output logic [7:0]       rsp_status,// Status byte of the last reply.
    output logic [31:0]      rsp_data   // Data word of the last reply.
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1, ST_LOW = 4'h2, ST_HIGH = 4'h4, ST_END = 4'h8
    } host_state_t;

    host_state_t state_ff;
    logic [39:0] tx_ff;
    logic [39:0] rx_ff;
    logic [5:0]  bit_cnt_ff;
    logic [3:0]  div_ff;
    logic        sclk_ff;
    logic        sel_n_ff;
    logic        mosi_ff;
    logic        busy_ff;
    logic        done_ff;
    logic [7:0]  status_ff;
    logic [31:0] data_ff;
    logic [1:0]  miso_sync_ff;

    wire         tick     = div_ff == CLK_DIV[3:0] - 4'h1;
    wire         last_bit = bit_cnt_ff == FRAME_BITS[5:0] - 6'h01;
    wire [39:0]  frame    = {req_write, req_index, req_data};

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            miso_sync_ff <= 2'h0;
        end else if (clk_en) begin
            miso_sync_ff <= {miso_sync_ff[0], link.miso};
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff   <= ST_IDLE;
            tx_ff      <= {FRAME_BITS{1'b0}};
            rx_ff      <= {FRAME_BITS{1'b0}};
            bit_cnt_ff <= BIT_CNT_RST;
            div_ff     <= DIV_CNT_RST;
            sclk_ff    <= 1'b1;
            sel_n_ff   <= 1'b1;
            mosi_ff    <= 1'b0;
            busy_ff    <= 1'b0;
            done_ff    <= 1'b0;
            status_ff  <= STATUS_RST;
            data_ff    <= REG_RST;
        end else if (clk_en) begin
            done_ff <= 1'b0;
            div_ff  <= tick ? DIV_CNT_RST : div_ff + 4'h1;
            case (state_ff)
                ST_IDLE: begin
                    div_ff <= DIV_CNT_RST;
                    if (req) begin
                        tx_ff      <= frame;
                        mosi_ff    <= frame[39];
                        sel_n_ff   <= 1'b0;
                        busy_ff    <= 1'b1;
                        bit_cnt_ff <= BIT_CNT_RST;
                        state_ff   <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    // Data moves on the falling edge so that it is settled
                    // when the device samples at the rising edge.
                    if (tick) begin
                        sclk_ff  <= 1'b0;
                        mosi_ff  <= tx_ff[39];
                        tx_ff    <= {tx_ff[38:0], 1'b0};
                        state_ff <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (tick) begin
                        sclk_ff <= 1'b1;
                        rx_ff   <= {rx_ff[38:0], miso_sync_ff[1]};
                        if (last_bit) begin
                            state_ff <= ST_END;
                        end else begin
                            bit_cnt_ff <= bit_cnt_ff + 6'h01;
                            state_ff   <= ST_LOW;
                        end
                    end
                end
                ST_END: begin
                    if (tick) begin
                        sel_n_ff  <= 1'b1;
                        busy_ff   <= 1'b0;
                        done_ff   <= 1'b1;
                        status_ff <= rx_ff[ADDR_MSB:ADDR_LSB];
                        data_ff   <= rx_ff[DATA_BITS-1:0];
                        state_ff  <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    assign link.sclk            = sclk_ff;
    assign link.select_low_line = sel_n_ff;
    assign link.mosi            = mosi_ff;
    assign busy       = busy_ff;
    assign done       = done_ff;
    assign rsp_status = status_ff;
    assign rsp_data   = data_ff;
endmodule : dgram_host
`default_nettype wire

//--- test/dgram_monitor.sv
// Wire checker for the datagram link joining host and device.
// Assumes both ends run on mclk and the serial clock idles high.
`default_nettype none
module dgram_monitor (
    input wire logic mclk,            // System clock.
    input wire logic sys_rst,         // Asynchronous reset.
    input wire logic sclk,            // Serial clock.
    input wire logic select_low_line, // Frame select.
    input wire logic mosi,            // Host data.
    input wire logic miso             // Device data.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic       sclk_ff;
    logic [5:0] rise_ff;
    logic [9:0] low_ff;
    wire        sclk_up  = sclk & ~sclk_ff & ~select_low_line;
    wire  [5:0] nxt_rise = select_low_line ? 6'h00 : rise_ff + {5'h00, sclk_up};
    wire  [9:0] nxt_low  = select_low_line ? 10'h000 : low_ff + 10'h001;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_ff <= 1'b1;
            rise_ff <= 6'h00;
            low_ff  <= 10'h000;
        end else begin
            sclk_ff <= sclk;
            rise_ff <= nxt_rise;
            low_ff  <= nxt_low;
        end
    end
    sequence half_low_s;
        (!sclk)[*8] ##1 sclk;
    endsequence
    sequence lead_in_s;
        sclk[*8] ##1 !sclk;
    endsequence
    idle_high_a: assert property (select_low_line |-> sclk)
        else $error("serial clock low outside a frame");
    clock_gate_a: assert property ($changed(sclk) |-> !select_low_line)
        else $error("serial clock moved while deselected");
    half_low_a: assert property ($fell(sclk) |-> half_low_s)
        else $error("serial clock low phase has the wrong length");
    lead_in_a: assert property ($fell(select_low_line) |-> lead_in_s)
        else $error("first clock fall not eight cycles after select");
    mosi_hold_a: assert property ($rose(sclk) |-> $stable(mosi))
        else $error("host data moved at the sampling edge");
    miso_hold_a: assert property ($rose(sclk) |-> $stable(miso))
        else $error("device data moved at the sampling edge");
    bit_count_a: assert property ($rose(select_low_line) |-> rise_ff == 6'h28)
        else $error("frame did not carry forty clocks");
    frame_len_a: assert property ($rose(select_low_line) |-> low_ff == 10'h288)
        else $error("frame select low for the wrong time");
endmodule : dgram_monitor
`default_nettype wire

//--- test/spi_datagram_framing_tb_top.sv
// Bench: host and device on one link, a spare device on a bench-driven link.
// Assumes eight mclk cycles per half period of the host's serial clock; the bench-driven link uses four.
`default_nettype none
module spi_datagram_framing_tb_top;
    import dgram_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, sys_rst, run, req, req_write, busy, done, wr_strobe, b_strobe;
    logic        b_sclk, b_sel, b_mosi;
    logic [6:0]  req_index, wr_index, b_index;
    logic [7:0]  status_in, rsp_status;
    logic [31:0] req_data, ro_value, rsp_data, wr_data, b_data;
    int          miscompares = 0;
    int          checked = 0;
    int          cyc = 0;
    dgram_if lk ();
    dgram_if lk2 ();
    assign lk2.sclk = b_sclk;
    assign lk2.select_low_line = b_sel;
    assign lk2.mosi = b_mosi;
    dgram_host i_dgram_host (.mclk(mclk), .sys_rst(sys_rst), .clk_en(run), .link(lk.host),
        .req(req), .req_write(req_write), .req_index(req_index), .req_data(req_data),
        .busy(busy), .done(done), .rsp_status(rsp_status), .rsp_data(rsp_data));
    dgram_dev i_dgram_dev (.mclk(mclk), .sys_rst(sys_rst), .clk_en(run), .link(lk.dev),
        .status_in(status_in), .ro_value(ro_value), .wr_strobe(wr_strobe),
        .wr_index(wr_index), .wr_data(wr_data));
    // Second device lets the bench send frames the host never would.
    dgram_dev i_dgram_dev_b (.mclk(mclk), .sys_rst(sys_rst), .clk_en(run), .link(lk2.dev),
        .status_in(status_in), .ro_value(ro_value), .wr_strobe(b_strobe),
        .wr_index(b_index), .wr_data(b_data));
    dgram_monitor i_dgram_monitor (.mclk(mclk), .sys_rst(sys_rst), .sclk(lk.sclk),
        .select_low_line(lk.select_low_line), .mosi(lk.mosi), .miso(lk.miso));
    task automatic test_done();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic xfer(logic w, logic [6:0] idx, logic [31:0] d, logic [31:0] exp, logic stb);
        int n;
        @(posedge mclk);
        status_in <= {1'b1, idx};
        req <= 1'b1;
        req_write <= w;
        req_index <= idx;
        req_data <= d;
        for (n = 0; n < 20 && busy !== 1'b1; n++) @(negedge mclk);
        @(posedge mclk);
        req <= 1'b0;
        for (n = 0; n < 1000 && done !== 1'b1; n++) @(negedge mclk);
        check("status", rsp_status, {1'b1, idx});
        check("data", rsp_data, exp);
        for (n = 0; n < 8 && wr_strobe !== 1'b1; n++) @(negedge mclk);
        check("strobe", n < 8, stb);
        if (stb) check("write", {wr_index, wr_data}, {idx, d});
    endtask : xfer
    task automatic raw(int nb, logic [47:0] v);
        @(posedge mclk);
        b_sel <= 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            repeat (4) @(posedge mclk);
            b_sclk <= 1'b0;
            b_mosi <= v[i];
            repeat (4) @(posedge mclk);
            b_sclk <= 1'b1;
        end
        repeat (4) @(posedge mclk);
        b_sel <= 1'b1;
        b_mosi <= ~v[0];
        for (int i = 0; i < 12 && b_strobe !== 1'b1; i++) @(negedge mclk);
    endtask : raw
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        {sys_rst, run, b_sclk, b_sel} = 4'hf;
        {req, req_write, b_mosi} = 3'h0;
        req_index = 7'h00;
        req_data = 32'h0;
        status_in = 8'h00;
        ro_value = 32'h0bad_cafe;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        xfer(1'b1, 7'h03, 32'h1234_5678, 32'h0, 1'b1);
        xfer(1'b0, 7'h03, 32'h0, 32'h1234_5678, 1'b0);
        xfer(1'b0, 7'h40, 32'h0, 32'h1234_5678, 1'b0);
        xfer(1'b1, 7'h40, 32'ha5a5_0f0f, 32'h0, 1'b1);
        // Frozen clock enable between frames must keep the pending reply.
        run <= 1'b0;
        repeat (40) @(posedge mclk);
        check("frozen busy", busy, 1'b0);
        run <= 1'b1;
        xfer(1'b0, 7'h65, 32'h0, 32'ha5a5_0f0f, 1'b0);
        xfer(1'b1, 7'h65, 32'hdead_beef, 32'h0bad_cafe, 1'b0);
        xfer(1'b0, 7'h03, 32'h0, 32'hdead_beef, 1'b0);
        xfer(1'b0, 7'h1f, 32'h0, 32'h1234_5678, 1'b0);
        raw(48, {8'hff, 1'b1, 7'h07, 32'hcafe_0001});
        check("long strobe", b_strobe, 1'b1);
        check("long write", {b_index, b_data}, {7'h07, 32'hcafe_0001});
        raw(39, {8'h00, 1'b1, 7'h08, 32'h0000_0011});
        check("short strobe", b_strobe, 1'b0);
        test_done();
    end
endmodule : spi_datagram_framing_tb_top
`default_nettype wire
